/* File: pgs_pkg.sv */
// constants, register map and types of the pre-positioning grip sequencer
package pgs_pkg;
  // register byte offsets
  localparam logic [7:0] ADDR_COMMAND = 8'h00;
  localparam logic [7:0] ADDR_PROFILE = 8'h04;
  localparam logic [7:0] ADDR_PARAM_LAST = 8'h24;
  localparam logic [7:0] ADDR_FLAGS = 8'h28;
  localparam logic [7:0] ADDR_FAULT = 8'h2c;
  localparam logic [7:0] ADDR_CUR_POS = 8'h30;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h34;
  localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h38;
  localparam logic [7:0] ADDR_IRQ_CLEAR = 8'h3c;
  // parameter slots, in register order from ADDR_PROFILE
  localparam int PI_PROFILE = 0;
  localparam int PI_RECIPE = 1;
  localparam int PI_WINDOW = 2;
  localparam int PI_FORCE = 3;
  localparam int PI_SPEED = 4;
  localparam int PI_OPEN = 5;
  localparam int PI_SHIFT = 6;
  localparam int PI_PART = 7;
  localparam int PI_CLOSED = 8;
  localparam int N_PARAMS = 9;
  // command word values
  localparam logic [15:0] CMD_NONE = 16'h0000;
  localparam logic [15:0] CMD_XFER = 16'h0001;
  localparam logic [15:0] CMD_CLR_DIR = 16'h0004;
  localparam logic [15:0] CMD_OPEN = 16'h0100;
  localparam logic [15:0] CMD_CLOSE = 16'h0200;
  // profile numbers
  localparam logic [15:0] PROF_MOTOR_ON = 16'h0003;
  localparam logic [15:0] PROF_MOTOR_OFF = 16'h0005;
  localparam logic [15:0] PROF_OUTSIDE = 16'h0052;
  localparam logic [15:0] PROF_INSIDE = 16'h005c;
  // state flag word bits
  localparam int SF_MOTOR_ON = 1;
  localparam int SF_BUSY = 4;
  localparam int SF_HOST_ALIVE = 6;
  localparam int SF_GRIPPED = 7;
  localparam int SF_AT_OPEN = 8;
  localparam int SF_AT_PART = 9;
  localparam int SF_AT_CLOSED = 10;
  localparam int SF_AT_NONE = 11;
  localparam int SF_PARAMS_OK = 12;
  localparam int SF_DIR_CLOSE = 13;
  localparam int SF_DIR_OPEN = 14;
  // interrupt status bits
  localparam int IRQ_W = 4;
  localparam int IRQ_ACCEPT = 0;
  localparam int IRQ_DONE = 1;
  localparam int IRQ_GRIP = 2;
  localparam int IRQ_NOPART = 3;
  // fault codes
  localparam logic [15:0] FAULT_NONE = 16'h0000;
  localparam logic [15:0] FAULT_BAD_PROFILE = 16'h0001;
  localparam logic [15:0] FAULT_MOTOR_OFF = 16'h0002;
  // boot time of the internal controller
  localparam int CLK_KHZ = 10000;
  localparam int BOOT_TIME_US = 10;
  localparam int BOOT_CYCLES = (BOOT_TIME_US * CLK_KHZ + 999) / 1000;
  localparam logic [15:0] OVERRUN_DEFAULT = 16'h0014;
  // sequencer states
  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_PRESHIFT = 3'b001,
    S_GRIP = 3'b010,
    S_HOLD = 3'b011,
    S_OVERRUN = 3'b100,
    S_RETURN = 3'b101,
    S_RELEASE = 3'b110,
    S_DONE = 3'b111
  } pgs_state_t;
endpackage : pgs_pkg

/* File: pgs_pos_flags.sv */
// position window comparators for the named positions and the drive target
`timescale 1ns/1ps
module pgs_pos_flags #(
  parameter int POS_W = 16
) (
  // measured position and tolerance
  input wire logic [POS_W-1:0] i_pos,
  input wire logic [POS_W-1:0] i_window,
  // reference positions: open end, expected part, closed end, drive target
  input wire logic [POS_W-1:0] i_open,
  input wire logic [POS_W-1:0] i_part,
  input wire logic [POS_W-1:0] i_closed,
  input wire logic [POS_W-1:0] i_target,
  // window hits, same order
  output logic [3:0] o_hit
);
  logic [POS_W-1:0] refs [0:3];

  assign refs[0] = i_open;
  assign refs[1] = i_part;
  assign refs[2] = i_closed;
  assign refs[3] = i_target;

  // tolerance applies in both directions
  for (genvar g = 0; g < 4; g++) begin : g_cmp
    logic [POS_W-1:0] diff;
    assign diff = (i_pos >= refs[g]) ? (i_pos - refs[g]) : (refs[g] - i_pos);
    assign o_hit[g] = (diff <= i_window);
  end
endmodule : pgs_pos_flags

/* File: pgs_sequencer.sv */
// pre-positioning grip sequencer with ahb-lite register slave
`timescale 1ns/1ps
// How it works
// - mode 82 close: preposition, then force grip
// - mode 82 open: position to open end
// - mode 82 no part: overrun, return, stop closed
// - current rise means contact; hold grip force
// - mode 92 open: preposition, then grip outward
// - mode 92 close: position to closed end
// - mode 92 no part: overrun, stop open
// - mode 92 grip starts with positioning phase
// - acknowledge bit 12; motor off clears bit 1
// - report state, fault, position after boot
// - position flags bits 8 to 11
// - new handshake abandons running motion
module pgs_sequencer
  import pgs_pkg::*;
#(
  parameter int POS_W = 16,
  parameter logic [15:0] OVERRUN_DIST = pgs_pkg::OVERRUN_DEFAULT,
  parameter int BOOT_CNT = pgs_pkg::BOOT_CYCLES
) (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_reset_n,
  // ahb-lite slave
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic [31:0] o_hrdata,
  output logic o_hreadyout,
  output logic o_hresp,
  // drive feedback
  input wire logic [POS_W-1:0] i_current_pos,
  input wire logic i_current_rise,
  // drive command
  output logic o_drive_en,
  output logic o_force_mode,
  output logic [POS_W-1:0] o_drive_target,
  output logic [15:0] o_drive_speed,
  output logic [15:0] o_force_limit,
  // interrupt
  output logic o_irq
);
  import pgs_pkg::*;

  initial begin
    if (POS_W < 8 || POS_W > 16) $error("POS_W must be 8..16");
    if (BOOT_CNT < 1 || BOOT_CNT > 65535) $error("BOOT_CNT out of range");
  end

  logic booted;
  logic [15:0] boot_cnt;
  logic [15:0] command_word;
  logic [15:0] command_prev;
  logic [15:0] shadow [0:N_PARAMS-1];
  logic [15:0] active [0:N_PARAMS-1];
  logic params_accepted_flag;
  logic motor_on;
  logic gripped;
  logic dir_close;
  logic dir_open;
  logic [15:0] fault_code;
  logic [IRQ_W-1:0] irq_status;
  logic [IRQ_W-1:0] irq_enable;
  logic [IRQ_W-1:0] irq_set;
  pgs_state_t state;
  pgs_state_t next_state;
  logic [POS_W-1:0] grip_end;
  logic grip_up;
  logic [POS_W-1:0] next_target;
  logic next_force;
  logic [15:0] next_speed;
  logic [3:0] hit;
  logic [15:0] state_flags_word;
  logic ap_take;
  logic wr_pend;
  logic [7:0] wr_addr;
  logic [31:0] rd_value;
  logic addr_ok;
  logic xfer_start;
  logic cmd_edge;
  logic move_close;
  logic move_open;
  logic mode_out;
  logic mode_in;
  logic move_ok;

  // bus slave: zero wait states, always okay
  assign o_hreadyout = 1'b1;
  assign o_hresp = 1'b0;
  assign ap_take = i_hsel && i_htrans[1] && i_hready;
  assign addr_ok = (i_haddr[31:8] == 24'h000000) && (i_haddr[1:0] == 2'b00);

  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
    end else begin
      wr_pend <= ap_take && i_hwrite && addr_ok;
      wr_addr <= i_haddr[7:0];
    end
  end

  // boot: nothing is reported, and no command or parameter write is accepted, before the controller is up
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      boot_cnt <= 16'h0000;
      booted <= 1'b0;
    end else if (!booted) begin
      boot_cnt <= boot_cnt + 16'h0001;
      booted <= (boot_cnt == 16'(BOOT_CNT - 1));
    end
  end

  // host-written command word and parameter shadows
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      command_word <= CMD_NONE;
      command_prev <= CMD_NONE;
    end else begin
      command_prev <= command_word;
      if (wr_pend && booted && wr_addr == ADDR_COMMAND) begin
        command_word <= i_hwdata[15:0];
      end
    end
  end

  for (genvar p = 0; p < N_PARAMS; p++) begin : g_param
    localparam logic [7:0] PADDR = ADDR_PROFILE + 8'(4 * p);
    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
        shadow[p] <= 16'h0000;
        active[p] <= 16'h0000;
      end else begin
        if (wr_pend && booted && wr_addr == PADDR) begin
          shadow[p] <= i_hwdata[15:0];
        end
        if (xfer_start) begin
          active[p] <= shadow[p];
        end
      end
    end
  end

  assign cmd_edge = (command_word != command_prev);
  assign xfer_start = cmd_edge && (command_word == CMD_XFER);

  // handshake acknowledge and motor power
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      params_accepted_flag <= 1'b0;
      motor_on <= 1'b0;
    end else begin
      if (xfer_start) begin
        params_accepted_flag <= 1'b1;
        if (shadow[PI_PROFILE] == PROF_MOTOR_OFF) begin
          motor_on <= 1'b0;
        end else begin
          motor_on <= 1'b1;
        end
      end else if (command_word != CMD_XFER) begin
        params_accepted_flag <= 1'b0;
      end
    end
  end

  // move decode
  assign mode_out = (active[PI_PROFILE] == PROF_OUTSIDE);
  assign mode_in = (active[PI_PROFILE] == PROF_INSIDE);
  assign move_close = cmd_edge && (command_word == CMD_CLOSE);
  assign move_open = cmd_edge && (command_word == CMD_OPEN);
  assign move_ok = motor_on && !params_accepted_flag && (mode_out || mode_in);

  function automatic logic [POS_W-1:0] overrun_pos(input logic [POS_W-1:0] pos,
                                                   input logic up);
    logic [POS_W:0] sum;
    sum = {1'b0, pos};
    if (up) begin
      sum = sum + {1'b0, OVERRUN_DIST[POS_W-1:0]};
      overrun_pos = sum[POS_W] ? {POS_W{1'b1}} : sum[POS_W-1:0];
    end else begin
      overrun_pos = (pos > OVERRUN_DIST[POS_W-1:0]) ? pos - OVERRUN_DIST[POS_W-1:0] : '0;
    end
  endfunction : overrun_pos

  // sequencer next state
  always_comb begin
    next_state = state;
    next_target = o_drive_target;
    next_force = o_force_mode;
    next_speed = o_drive_speed;
    irq_set = '0;
    if (xfer_start) begin
      next_state = S_IDLE;
      next_target = i_current_pos;
      next_force = 1'b0;
      irq_set[IRQ_ACCEPT] = 1'b1;
    end else if ((move_close || move_open) && move_ok) begin
      next_speed = active[PI_SPEED];
      next_force = 1'b0;
      if ((mode_out && move_close) || (mode_in && move_open)) begin
        next_state = S_PRESHIFT;
        next_target = active[PI_SHIFT][POS_W-1:0];
      end else if (mode_out) begin
        next_state = S_RELEASE;
        next_target = active[PI_OPEN][POS_W-1:0];
      end else begin
        next_state = S_RELEASE;
        next_target = active[PI_CLOSED][POS_W-1:0];
      end
    end else begin
      case (state)
        S_PRESHIFT: begin
          if (hit[3]) begin
            next_state = S_GRIP;
            next_target = grip_end;
            next_force = 1'b1;
          end
        end
        S_GRIP: begin
          if (i_current_rise) begin
            next_state = S_HOLD;
            irq_set[IRQ_GRIP] = 1'b1;
          end else if (hit[3]) begin
            next_state = S_OVERRUN;
            next_target = overrun_pos(grip_end, grip_up);
            next_force = 1'b0;
          end
        end
        S_OVERRUN: begin
          if (hit[3]) begin
            next_state = S_RETURN;
            next_target = grip_end;
          end
        end
        S_RETURN: begin
          if (i_current_pos == grip_end) begin
            next_state = S_DONE;
            irq_set[IRQ_NOPART] = 1'b1;
            irq_set[IRQ_DONE] = 1'b1;
          end
        end
        S_RELEASE: begin
          if (hit[3]) begin
            next_state = S_DONE;
            irq_set[IRQ_DONE] = 1'b1;
          end
        end
        S_HOLD: next_state = S_HOLD;
        S_IDLE: next_state = S_IDLE;
        S_DONE: next_state = S_DONE;
        default: next_state = S_IDLE;
      endcase
    end
    if (!motor_on) begin
      next_state = S_IDLE;
      next_force = 1'b0;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state <= S_IDLE;
      o_drive_target <= '0;
      o_force_mode <= 1'b0;
      o_drive_speed <= 16'h0000;
      o_force_limit <= 16'h0000;
      o_drive_en <= 1'b0;
    end else begin
      state <= next_state;
      o_drive_target <= next_target;
      o_force_mode <= next_force;
      o_drive_speed <= next_speed;
      o_force_limit <= active[PI_FORCE];
      o_drive_en <= motor_on;
    end
  end

  // grip end and direction are fixed when a grip stroke starts
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      grip_end <= '0;
      grip_up <= 1'b0;
    end else if ((move_close || move_open) && move_ok && !xfer_start) begin
      if (mode_out) begin
        grip_end <= active[PI_CLOSED][POS_W-1:0];
        grip_up <= active[PI_CLOSED] >= active[PI_SHIFT];
      end else begin
        grip_end <= active[PI_OPEN][POS_W-1:0];
        grip_up <= active[PI_OPEN] >= active[PI_SHIFT];
      end
    end
  end

  // gripped, direction flags and fault code
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      gripped <= 1'b0;
      dir_close <= 1'b0;
      dir_open <= 1'b0;
      fault_code <= FAULT_NONE;
    end else begin
      gripped <= (next_state == S_HOLD);
      if (cmd_edge && command_word == CMD_CLR_DIR) begin
        dir_close <= 1'b0;
        dir_open <= 1'b0;
      end else if (move_close && move_ok && !xfer_start) begin
        dir_close <= 1'b1;
        dir_open <= 1'b0;
      end else if (move_open && move_ok && !xfer_start) begin
        dir_close <= 1'b0;
        dir_open <= 1'b1;
      end
      if (xfer_start) begin
        fault_code <= FAULT_NONE;
      end else if ((move_close || move_open) && !params_accepted_flag) begin
        if (!motor_on) begin
          fault_code <= FAULT_MOTOR_OFF;
        end else if (!(mode_out || mode_in)) begin
          fault_code <= FAULT_BAD_PROFILE;
        end
      end
    end
  end

  pgs_pos_flags #(
    .POS_W(POS_W)
  ) u_pos_flags (
    .i_pos(i_current_pos),
    .i_window(active[PI_WINDOW][POS_W-1:0]),
    .i_open(active[PI_OPEN][POS_W-1:0]),
    .i_part(active[PI_PART][POS_W-1:0]),
    .i_closed(active[PI_CLOSED][POS_W-1:0]),
    .i_target(o_drive_target),
    .o_hit(hit)
  );

  // state flag word
  always_comb begin
    state_flags_word = 16'h0000;
    state_flags_word[SF_MOTOR_ON] = motor_on;
    state_flags_word[SF_BUSY] = (state != S_IDLE) && (state != S_DONE) && (state != S_HOLD);
    state_flags_word[SF_HOST_ALIVE] = booted;
    state_flags_word[SF_GRIPPED] = gripped;
    state_flags_word[SF_AT_OPEN] = hit[0];
    state_flags_word[SF_AT_PART] = hit[1];
    state_flags_word[SF_AT_CLOSED] = hit[2];
    state_flags_word[SF_AT_NONE] = !(hit[0] || hit[1] || hit[2]);
    state_flags_word[SF_PARAMS_OK] = params_accepted_flag;
    state_flags_word[SF_DIR_CLOSE] = dir_close;
    state_flags_word[SF_DIR_OPEN] = dir_open;
  end

  // interrupts: set wins over clear
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      irq_status <= '0;
      irq_enable <= '0;
    end else begin
      if (wr_pend && wr_addr == ADDR_IRQ_ENABLE) begin
        irq_enable <= i_hwdata[IRQ_W-1:0];
      end
      if (wr_pend && wr_addr == ADDR_IRQ_CLEAR) begin
        irq_status <= (irq_status & ~i_hwdata[IRQ_W-1:0]) | irq_set;
      end else begin
        irq_status <= irq_status | irq_set;
      end
    end
  end

  assign o_irq = |(irq_status & irq_enable);

  // read mux; nothing reported before boot
  always_comb begin
    rd_value = 32'h00000000;
    if (booted && addr_ok) begin
      if (i_haddr[7:0] == ADDR_COMMAND) begin
        rd_value = {16'h0000, command_word};
      end else if (i_haddr[7:0] >= ADDR_PROFILE && i_haddr[7:0] <= ADDR_PARAM_LAST) begin
        rd_value = {16'h0000, shadow[4'((i_haddr[7:0] - ADDR_PROFILE) >> 2)]};
      end else if (i_haddr[7:0] == ADDR_FLAGS) begin
        rd_value = {16'h0000, state_flags_word};
      end else if (i_haddr[7:0] == ADDR_FAULT) begin
        rd_value = {16'h0000, fault_code};
      end else if (i_haddr[7:0] == ADDR_CUR_POS) begin
        rd_value = {16'h0000, 16'(i_current_pos)};
      end else if (i_haddr[7:0] == ADDR_IRQ_STATUS) begin
        rd_value = {{(32 - IRQ_W){1'b0}}, irq_status};
      end else if (i_haddr[7:0] == ADDR_IRQ_ENABLE) begin
        rd_value = {{(32 - IRQ_W){1'b0}}, irq_enable};
      end
    end
  end

  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_hrdata <= 32'h00000000;
    end else if (ap_take && !i_hwrite) begin
      o_hrdata <= rd_value;
    end
  end
endmodule : pgs_sequencer

/* File: pgs_props.sv */
// assertion checker for the pre-positioning grip sequencer ports
`timescale 1ns/1ps
module pgs_props
  import pgs_pkg::*;
#(
  parameter int POS_W = 16,
  parameter int BOOT_CNT = pgs_pkg::BOOT_CYCLES
) (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_reset_n,
  // register bus
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [31:0] i_hwdata,
  input wire logic [31:0] o_hrdata,
  input wire logic o_hreadyout,
  input wire logic o_hresp,
  // drive side
  input wire logic [POS_W-1:0] i_current_pos,
  input wire logic i_current_rise,
  input wire logic o_drive_en,
  input wire logic o_force_mode,
  input wire logic [POS_W-1:0] o_drive_target
);
  logic [15:0] up_cnt;
  logic [3:0] since_cmd;
  logic cmd_ap;
  logic rd_ap;
  assign cmd_ap = i_hsel && i_htrans[1] && i_hwrite && (i_haddr == 32'(ADDR_COMMAND));
  assign rd_ap = i_hsel && i_htrans[1] && !i_hwrite;
  // cycles since reset release and since the last command write
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      up_cnt <= '0;
      since_cmd <= 4'hf;
    end else begin
      if (up_cnt != 16'hffff) up_cnt <= up_cnt + 16'h0001;
      if (cmd_ap) since_cmd <= 4'h0;
      else if (since_cmd != 4'hf) since_cmd <= since_cmd + 4'h1;
    end
  end
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_reset_n);
  sequence s_hs_write;
    cmd_ap ##1 (i_hwdata[15:0] == CMD_XFER);
  endsequence
  sequence s_flags_read;
    rd_ap && (i_haddr == 32'(ADDR_FLAGS)) && (up_cnt > BOOT_CNT + 2);
  endsequence
  a_bus_okay: assert property (o_hreadyout && !o_hresp)
    else $error("bus answer not ready or not okay");
  a_rdata_stands: assert property ($changed(o_hrdata) |-> $past(rd_ap))
    else $error("read data changed without a read");
  a_force_retarget: assert property ($rose(o_force_mode) |-> $changed(o_drive_target))
    else $error("force phase began without a new target");
  a_drop_retarget: assert property ($fell(o_force_mode) |-> $changed(o_drive_target))
    else $error("force phase ended without a new target");
  a_grip_holds: assert property ($rose(i_current_rise) && o_force_mode
    |=> (o_force_mode && $stable(o_drive_target)) [*3])
    else $error("grip not held after contact");
  a_motor_follows: assert property ($changed(o_drive_en) |-> since_cmd <= 4'h6)
    else $error("motor state changed without a command write");
  a_hs_abandons: assert property (s_hs_write |-> ##[1:4] !o_force_mode)
    else $error("handshake did not stop the force phase");
  a_alive_booted: assert property (s_flags_read |=> o_hrdata[SF_HOST_ALIVE])
    else $error("host alive flag missing after boot");
  a_flag_none: assert property (s_flags_read
    |=> o_hrdata[SF_AT_NONE] == !(|o_hrdata[SF_AT_CLOSED:SF_AT_OPEN]))
    else $error("none-position flag inconsistent");
endmodule : pgs_props

bind pgs_sequencer pgs_props #(.POS_W(POS_W), .BOOT_CNT(BOOT_CNT)) u_props (
  .i_core_clk(i_core_clk), .i_reset_n(i_reset_n), .i_hsel(i_hsel), .i_haddr(i_haddr),
  .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hwdata(i_hwdata), .o_hrdata(o_hrdata),
  .o_hreadyout(o_hreadyout), .o_hresp(o_hresp), .i_current_pos(i_current_pos),
  .i_current_rise(i_current_rise), .o_drive_en(o_drive_en), .o_force_mode(o_force_mode),
  .o_drive_target(o_drive_target));

/* File: pgs_jaw_model.sv */
// behavioural jaw drive: follows the target, stops at a part in force mode
`timescale 1ns/1ps
module pgs_jaw_model #(
  parameter int POS_W = 16
) (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_reset_n,
  // drive command
  input wire logic i_drive_en,
  input wire logic i_force_mode,
  input wire logic [POS_W-1:0] i_drive_target,
  // workpiece and pacing
  input wire logic i_part_en,
  input wire logic [POS_W-1:0] i_part_pos,
  input wire logic i_slow,
  // feedback
  output logic [POS_W-1:0] o_pos,
  output logic o_rise
);
  logic tick;
  logic blocked;
  // a part only stops the jaws while force controlled
  assign blocked = i_part_en && i_force_mode && (o_pos == i_part_pos);
  assign o_rise = blocked && i_drive_en;
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_pos <= POS_W'(16'h0064);
      tick <= 1'b0;
    end else begin
      tick <= ~tick;
      if (i_drive_en && !blocked && (tick || !i_slow)) begin
        if (o_pos < i_drive_target) o_pos <= o_pos + 1'b1;
        else if (o_pos > i_drive_target) o_pos <= o_pos - 1'b1;
      end
    end
  end
endmodule : pgs_jaw_model

/* File: pgs_sequencer_tb_top.sv */
// self-checking bench for the pre-positioning grip sequencer
`timescale 1ns/1ps
module pgs_sequencer_tb_top;
  import pgs_pkg::*;
  localparam logic [15:0] PAR [N_PARAMS] = '{16'h0000, 16'h0000, 16'h0005, 16'h0032,
    16'h0010, 16'h0064, 16'h00c8, 16'h0118, 16'h012c};
  logic clk, rst_n, hsel, hwrite, hready, hresp, rise, drv_en, force_md, irq, part_en, slow;
  logic [31:0] haddr, hwdata, hrdata, v, w;
  logic [1:0] htrans;
  logic [15:0] pos, target, speed, flimit, part_pos, max_pos, min_pos;
  int err_total = 0;
  int n_checks = 0;
  int cyc = 0;
  pgs_sequencer #(.POS_W(16), .OVERRUN_DIST(16'h0014), .BOOT_CNT(10)) i_dut (
    .i_core_clk(clk), .i_reset_n(rst_n),
    .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite),
    .i_hsize(3'b010), .i_hwdata(hwdata), .i_hready(hready), .o_hrdata(hrdata),
    .o_hreadyout(hready), .o_hresp(hresp),
    .i_current_pos(pos), .i_current_rise(rise),
    .o_drive_en(drv_en), .o_force_mode(force_md), .o_drive_target(target),
    .o_drive_speed(speed), .o_force_limit(flimit), .o_irq(irq));
  pgs_jaw_model #(.POS_W(16)) i_jaw (
    .i_core_clk(clk), .i_reset_n(rst_n), .i_drive_en(drv_en), .i_force_mode(force_md),
    .i_drive_target(target), .i_part_en(part_en), .i_part_pos(part_pos),
    .i_slow(slow), .o_pos(pos), .o_rise(rise));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic wrap_up();
    if (err_total == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : wrap_up
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // one single-word transfer, address phase then data phase
  task automatic xfer(input logic wr_en, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= wr_en;
    haddr <= {24'h0, a};
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    r = hrdata;
  endtask : xfer
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    xfer(1'b1, a, d, r);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    xfer(1'b0, a, 32'h0, r);
  endtask : rd
  task automatic poll(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
    logic [31:0] r;
    int k;
    k = 0;
    do begin
      rd(a, r);
      k++;
    end while ((r & m) !== x && k < 2000);
    chk(r & m, x);
  endtask : poll
  task automatic mv(input logic [15:0] c, input logic [7:0] a, input logic [31:0] m,
                    input logic [31:0] x);
    wr(ADDR_COMMAND, {16'h0, c});
    poll(a, m, x);
  endtask : mv
  task automatic hs(input logic [15:0] prof);
    logic [31:0] r;
    wr(ADDR_PROFILE, {16'h0, prof});
    for (int i = 1; i < N_PARAMS; i++) wr(ADDR_PROFILE + 8'(4 * i), {16'h0, PAR[i]});
    wr(ADDR_COMMAND, 32'h1);
    poll(ADDR_FLAGS, 32'h1000, 32'h1000);
    rd(ADDR_FLAGS, r);
    chk(32'(r[SF_MOTOR_ON]), 32'(prof != PROF_MOTOR_OFF));
    wr(ADDR_COMMAND, 32'h0);
    poll(ADDR_FLAGS, 32'h1000, 32'h0);
  endtask : hs
  task automatic fault_after_close(input logic [15:0] code);
    wr(ADDR_COMMAND, {16'h0, CMD_CLOSE});
    repeat (3) @(posedge clk);
    rd(ADDR_FAULT, v);
    chk(v, {16'h0, code});
  endtask : fault_after_close
  // hang guard and travel extremes
  always @(posedge clk) begin
    cyc++;
    if (pos > max_pos) max_pos <= pos;
    if (pos < min_pos) min_pos <= pos;
    if (cyc == 80000) begin
      err_total++;
      wrap_up();
    end
  end
  initial begin
    rst_n = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hwdata = 32'h0;
    part_en = 1'b0;
    part_pos = 16'h0118;
    slow = 1'b0;
    max_pos = 16'h0;
    min_pos = 16'hffff;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(ADDR_FLAGS, v);
    chk(v, 32'h0);
    poll(ADDR_FLAGS, 32'h40, 32'h40);
    rd(ADDR_CUR_POS, v);
    chk(v, 32'h64);
    rd(8'h80, v);
    chk(v, 32'h0);
    wr(ADDR_IRQ_ENABLE, 32'h1);
    rd(ADDR_IRQ_ENABLE, v);
    chk(v, 32'h1);
    hs(PROF_OUTSIDE);
    chk(32'(irq), 32'h1);
    wr(ADDR_IRQ_CLEAR, 32'h1);
    @(posedge clk);
    chk(32'(irq), 32'h0);
    part_en <= 1'b1;
    mv(CMD_CLOSE, ADDR_FLAGS, 32'h80, 32'h80);
    chk({16'h0, speed}, 32'h10);
    chk({16'h0, flimit}, 32'h32);
    rd(ADDR_CUR_POS, v);
    chk(v, 32'h118);
    rd(ADDR_FLAGS, v);
    chk(v & 32'hf00, 32'h200);
    hs(PROF_OUTSIDE);
    chk(32'(force_md), 32'h0);
    mv(CMD_OPEN, ADDR_CUR_POS, 32'hffff, 32'h64);
    rd(ADDR_FLAGS, v);
    chk(v & 32'hf00, 32'h100);
    part_en <= 1'b0;
    wr(ADDR_IRQ_CLEAR, 32'hf);
    wr(ADDR_IRQ_ENABLE, 32'hf);
    mv(CMD_CLOSE, ADDR_FLAGS, 32'h410, 32'h400);
    rd(ADDR_CUR_POS, v);
    chk(v, 32'h12c);
    chk(32'(max_pos > 16'h012c), 32'h1);
    rd(ADDR_IRQ_STATUS, v);
    chk(v & 32'ha, 32'ha);
    chk(32'(irq), 32'h1);
    wr(ADDR_IRQ_ENABLE, 32'h0);
    @(posedge clk);
    chk(32'(irq), 32'h0);
    wr(ADDR_IRQ_CLEAR, 32'hf);
    rd(ADDR_IRQ_STATUS, v);
    chk(v, 32'h0);
    hs(PROF_INSIDE);
    slow <= 1'b1;
    part_en <= 1'b1;
    part_pos <= 16'h0096;
    mv(CMD_OPEN, ADDR_FLAGS, 32'h80, 32'h80);
    rd(ADDR_CUR_POS, v);
    chk(v, 32'h96);
    mv(CMD_CLOSE, ADDR_CUR_POS, 32'hffff, 32'h12c);
    part_pos <= 16'h0118;
    wr(ADDR_COMMAND, {16'h0, CMD_OPEN});
    repeat (4) @(posedge clk);
    chk(32'(force_md), 32'h0);
    chk({16'h0, target}, {16'h0, PAR[PI_SHIFT]});
    poll(ADDR_FLAGS, 32'h110, 32'h100);
    rd(ADDR_CUR_POS, v);
    chk(v, 32'h64);
    chk(32'(min_pos < 16'h0064), 32'h1);
    rd(ADDR_FLAGS, v);
    chk(v & 32'h80, 32'h0);
    chk(v & 32'h6000, 32'h4000);
    wr(ADDR_COMMAND, {16'h0, CMD_CLR_DIR});
    poll(ADDR_FLAGS, 32'h6000, 32'h0);
    slow <= 1'b0;
    hs(PROF_OUTSIDE);
    wr(ADDR_COMMAND, {16'h0, CMD_CLOSE});
    repeat (30) @(posedge clk);
    hs(PROF_OUTSIDE);
    rd(ADDR_CUR_POS, v);
    repeat (20) @(posedge clk);
    rd(ADDR_CUR_POS, w);
    chk(w, v);
    hs(16'h0032);
    fault_after_close(FAULT_BAD_PROFILE);
    hs(PROF_MOTOR_OFF);
    chk(32'(drv_en), 32'h0);
    fault_after_close(FAULT_MOTOR_OFF);
    wrap_up();
  end
endmodule : pgs_sequencer_tb_top
